/* File: common/spwd_pkg.sv */
// Package with register map, timing constants, state types and helper functions of the split port watchdog.
`default_nettype none
package spwd_pkg;
   localparam int          AXI_AW        = 18;
   localparam int          MS_W          = 12;
   localparam int          LS_W          = 4;
   localparam logic [15:0] IDX_SPLIT_EN  = 16'h3c48;
   localparam logic [15:0] IDX_TIMEOUT   = 16'h4171;
   localparam logic [15:0] IDX_PULSE     = 16'h4176;
   localparam logic [15:0] IDX_STATUS    = 16'h4180;
   localparam logic [7:0]  RST_SPLIT_EN  = 8'h00;
   localparam logic [7:0]  RST_TIMEOUT   = 8'h05;
   localparam logic [7:0]  RST_PULSE     = 8'h05;
   localparam logic [7:0]  MASK_SPLIT_EN = 8'hfe;
   localparam logic [7:0]  MASK_TIMEOUT  = 8'h07;
   localparam int          BIT_EN_P3     = 5;
   localparam int          BIT_EN_P4     = 6;
   localparam int          ST_P4_LSB     = 4;
   localparam int          ST_PULSE_P3   = 8;
   localparam int          ST_PULSE_P4   = 9;
   localparam int          ST_BILLBOARD  = 10;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   localparam int          CLK_HZ        = 25_000_000;
   localparam int          MS_PER_S      = 1000;
   localparam int          TICK_CYCLES   = CLK_HZ / MS_PER_S;
   localparam int          TICK_W        = 16;
   localparam int          TO_1_MS       = 100;
   localparam int          TO_2_MS       = 250;
   localparam int          TO_3_MS       = 500;
   localparam int          TO_4_MS       = 750;
   localparam int          TO_5_MS       = 1000;
   localparam int          TO_6_MS       = 2000;
   localparam int          PULSE_MIN_MS  = 350;
   localparam int          PULSE_STEP_MS = 10;
   localparam logic [LS_W-1:0] LS_DISABLED = 4'h4;
   localparam logic [LS_W-1:0] LS_RXDETECT = 4'h5;
   localparam logic [LS_W-1:0] LS_INACTIVE = 4'h6;
   localparam logic [LS_W-1:0] LS_POLLING  = 4'h7;
   localparam logic [LS_W-1:0] LS_RECOVERY = 4'h8;
   localparam logic [LS_W-1:0] LS_HOTRESET = 4'h9;

   typedef enum logic {SPWD_MONITOR, SPWD_PULSE} spwd_phase_e;

   typedef struct packed {
      spwd_phase_e       phase;
      logic              power;
      logic [LS_W-1:0]   last_state;
      logic [MS_W-1:0]   count;
   } spwd_timer_s;

   typedef struct packed {
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              aw_got;
      logic              w_got;
      logic [15:0]       aw_idx;
      logic [7:0]        wdata;
      logic              wstrb0;
      logic              arready;
      logic              rvalid;
      logic [1:0]        rresp;
      logic [31:0]       rdata;
      logic [7:0]        split_en;
      logic [7:0]        tsel;
      logic [7:0]        pulse;
      logic [TICK_W-1:0] tick_cnt;
      logic              ms_tick;
      logic              req_s1;
      logic              req_s2;
      logic              bb_enum;
   } spwd_top_s;

   function automatic logic spwd_is_stuck(input logic [LS_W-1:0] st);
      return st == LS_DISABLED || st == LS_RXDETECT || st == LS_INACTIVE ||
             st == LS_POLLING || st == LS_RECOVERY || st == LS_HOTRESET;
   endfunction

   function automatic logic [MS_W-1:0] spwd_timeout_ms(input logic [2:0] sel);
      case (sel)
         3'h1: return MS_W'(TO_1_MS);
         3'h2: return MS_W'(TO_2_MS);
         3'h3: return MS_W'(TO_3_MS);
         3'h4: return MS_W'(TO_4_MS);
         3'h5: return MS_W'(TO_5_MS);
         3'h6: return MS_W'(TO_6_MS);
         default: return '0;
      endcase
   endfunction

   function automatic logic [MS_W-1:0] spwd_pulse_ms(input logic [7:0] n);
      return MS_W'(PULSE_MIN_MS + PULSE_STEP_MS * int'(n));
   endfunction
endpackage
`default_nettype wire

/* File: rtl/spwd_msg_mem.sv */
// Message memory that holds the failure text loaded from one-time-programmable storage.
`default_nettype none
module spwd_msg_mem #(
   parameter int AW = 6,
   parameter int DW = 8
) (
   input  wire logic          clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [DW-1:0] wdata,
   input  wire logic [AW-1:0] raddr,
   output var  logic [DW-1:0] rdata
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // Read data come out of a register so the descriptor path sees a clean flop.
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule
`default_nettype wire

/* File: rtl/spwd_port_timer.sv */
// Per-port stuck-link timer and split power pulse generator.
`default_nettype none
module spwd_port_timer (
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic                      ms_tick,
   input  wire logic                      enable,
   input  wire logic [spwd_pkg::LS_W-1:0] link_state,
   input  wire logic [spwd_pkg::MS_W-1:0] timeout_ms,
   input  wire logic [spwd_pkg::MS_W-1:0] pulse_ms,
   output var  logic                      power,
   output var  logic                      pulsing
);
   spwd_pkg::spwd_timer_s s;
   spwd_pkg::spwd_timer_s next_s;
   logic                  stuck;

   always_comb begin
      next_s = s;
      stuck = spwd_pkg::spwd_is_stuck(link_state);
      next_s.last_state = link_state;
      case (s.phase)
         spwd_pkg::SPWD_MONITOR: begin
            next_s.power = 1'b1;
            if (!enable) begin
               next_s.count = '0;
            end else if (link_state != s.last_state || !stuck || timeout_ms == '0) begin
               next_s.count = '0;
            end else if (ms_tick) begin
               if (s.count + 1'b1 >= timeout_ms) begin
                  next_s.count = '0;
                  next_s.phase = spwd_pkg::SPWD_PULSE;
                  next_s.power = 1'b0;
               end else begin
                  next_s.count = s.count + 1'b1;
               end
            end
         end
         spwd_pkg::SPWD_PULSE: begin
            next_s.power = 1'b0;
            if (!enable) begin
               next_s.phase = spwd_pkg::SPWD_MONITOR;
               next_s.power = 1'b1;
               next_s.count = '0;
            end else if (ms_tick) begin
               if (s.count + 1'b1 >= pulse_ms) begin
                  next_s.phase = spwd_pkg::SPWD_MONITOR;
                  next_s.power = 1'b1;
                  next_s.count = '0;
               end else begin
                  next_s.count = s.count + 1'b1;
               end
            end
         end
         default: next_s.phase = spwd_pkg::SPWD_MONITOR;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '{phase: spwd_pkg::SPWD_MONITOR, power: 1'b1, last_state: '0, count: '0};
      end else begin
         s <= next_s;
      end
   end

   assign power = s.power;
   assign pulsing = (s.phase == spwd_pkg::SPWD_PULSE);

   pin_low_pulse_a: assert property (@(posedge clk) disable iff (rst)
      !s.power |-> s.phase == spwd_pkg::SPWD_PULSE)
      else $error("Split power low outside a pulse.");
   no_timeout_idle_a: assert property (@(posedge clk) disable iff (rst)
      (s.phase == spwd_pkg::SPWD_MONITOR && timeout_ms == '0) |=> s.phase == spwd_pkg::SPWD_MONITOR)
      else $error("Pulse started with timeout disabled.");
   state_change_restart_a: assert property (@(posedge clk) disable iff (rst)
      (s.phase == spwd_pkg::SPWD_MONITOR && link_state != s.last_state) |=> s.count == '0)
      else $error("Timer not restarted on link state change.");
   expiry_pulse_a: assert property (@(posedge clk) disable iff (rst)
      (s.phase == spwd_pkg::SPWD_MONITOR && enable && ms_tick && stuck && link_state == s.last_state &&
       timeout_ms != '0 && s.count + 1'b1 >= timeout_ms) |=> (!s.power && s.count == '0))
      else $error("Expired timeout did not start a pulse.");
   pulse_end_a: assert property (@(posedge clk) disable iff (rst)
      (s.phase == spwd_pkg::SPWD_PULSE && enable && ms_tick && s.count + 1'b1 >= pulse_ms)
      |=> (s.power && s.count == '0 && s.phase == spwd_pkg::SPWD_MONITOR))
      else $error("Pulse did not end at its duration.");
   pulse_len_a: assert property (@(posedge clk) disable iff (rst)
      (s.phase == spwd_pkg::SPWD_PULSE && ms_tick && s.count + 1'b1 < pulse_ms && enable) |=> !s.power)
      else $error("Pulse ended early.");
   disabled_high_a: assert property (@(posedge clk) disable iff (rst)
      !enable |=> s.power)
      else $error("Disabled port pulsed.");
   pulse_seen_c: cover property (@(posedge clk) disable iff (rst) $fell(s.power));
   pulse_done_c: cover property (@(posedge clk) disable iff (rst) $rose(s.power));
endmodule
`default_nettype wire

/* File: rtl/spwd_top.sv */
// Top of the split port link watchdog with its register slave and billboard request logic.
//
// Behaviour
// - Judge link validity from link state status.
// - Same stuck state for full timeout pulses pin.
// - Select code picks timeout 100 ms to 2 s.
// - Select zero never pulses the pin.
// - Timeout select resets to five.
// - Timeout expiry clears and restarts counter.
// - Select writable by software, overridden by OTP.
// - Pin held low for programmed duration.
// - Duration is 350 ms plus 10 ms steps.
// - Duration timer cleared when pulse ends.
// - Duration used only for split pulses.
// - Only split enabled ports monitor and pulse.
// - Failure signal allows billboard enumeration.
// - Billboard descriptors carry OTP stored message.
// - Bits five and six enable ports three, four.
//
// The AXI4-Lite slave port was decided locally.
`default_nettype none
module spwd_top #(
   parameter int TICK_CYCLES = spwd_pkg::TICK_CYCLES,
   parameter int MSG_AW      = 6
) (
   input  wire logic                        CLK,
   input  wire logic                        RST,
   input  wire logic [spwd_pkg::AXI_AW-1:0] S_AXI_AWADDR,
   input  wire logic                        S_AXI_AWVALID,
   output var  logic                        S_AXI_AWREADY,
   input  wire logic [31:0]                 S_AXI_WDATA,
   input  wire logic [3:0]                  S_AXI_WSTRB,
   input  wire logic                        S_AXI_WVALID,
   output var  logic                        S_AXI_WREADY,
   output var  logic [1:0]                  S_AXI_BRESP,
   output var  logic                        S_AXI_BVALID,
   input  wire logic                        S_AXI_BREADY,
   input  wire logic [spwd_pkg::AXI_AW-1:0] S_AXI_ARADDR,
   input  wire logic                        S_AXI_ARVALID,
   output var  logic                        S_AXI_ARREADY,
   output var  logic [31:0]                 S_AXI_RDATA,
   output var  logic [1:0]                  S_AXI_RRESP,
   output var  logic                        S_AXI_RVALID,
   input  wire logic                        S_AXI_RREADY,
   input  wire logic [spwd_pkg::LS_W-1:0]   LINK_STATE_STATUS_P3,
   input  wire logic [spwd_pkg::LS_W-1:0]   LINK_STATE_STATUS_P4,
   output var  logic                        SUPERSPEED_SPLIT_POWER_PIN_P3,
   output var  logic                        SUPERSPEED_SPLIT_POWER_PIN_P4,
   input  wire logic                        OTP_TIMEOUT_VALID,
   input  wire logic [2:0]                  OTP_TIMEOUT_SEL,
   input  wire logic                        OTP_MSG_WE,
   input  wire logic [MSG_AW-1:0]           OTP_MSG_ADDR,
   input  wire logic [7:0]                  OTP_MSG_DATA,
   input  wire logic                        BILLBOARD_REQ_N,
   output var  logic                        BILLBOARD_ENUM,
   input  wire logic [MSG_AW-1:0]           DESC_ADDR,
   output var  logic [7:0]                  DESC_DATA
);
   spwd_pkg::spwd_top_s       s;
   spwd_pkg::spwd_top_s       next_s;
   logic                      have_aw;
   logic                      have_w;
   logic [15:0]               w_idx;
   logic [7:0]                w_byte;
   logic                      w_lane0;
   logic [15:0]               r_idx;
   logic [2:0]                eff_sel;
   logic [spwd_pkg::MS_W-1:0] timeout_ms;
   logic [spwd_pkg::MS_W-1:0] pulse_ms;
   logic                      pulsing_p3;
   logic                      pulsing_p4;

   localparam logic [spwd_pkg::TICK_W-1:0] TICK_LAST = spwd_pkg::TICK_W'(TICK_CYCLES - 1);

   always_comb begin
      // OTP value takes precedence over the software copy while it is valid.
      eff_sel = OTP_TIMEOUT_VALID ? OTP_TIMEOUT_SEL : s.tsel[2:0];
      timeout_ms = spwd_pkg::spwd_timeout_ms(eff_sel);
      pulse_ms = spwd_pkg::spwd_pulse_ms(s.pulse);
   end

   always_comb begin
      next_s = s;
      have_aw = s.aw_got || (S_AXI_AWVALID && s.awready);
      have_w = s.w_got || (S_AXI_WVALID && s.wready);
      w_idx = s.aw_got ? s.aw_idx : S_AXI_AWADDR[spwd_pkg::AXI_AW-1:2];
      w_byte = s.w_got ? s.wdata : S_AXI_WDATA[7:0];
      w_lane0 = s.w_got ? s.wstrb0 : S_AXI_WSTRB[0];
      r_idx = S_AXI_ARADDR[spwd_pkg::AXI_AW-1:2];

      // The millisecond tick paces both the timeout and the pulse counters.
      next_s.ms_tick = 1'b0;
      if (s.tick_cnt >= TICK_LAST) begin
         next_s.tick_cnt = '0;
         next_s.ms_tick = 1'b1;
      end else begin
         next_s.tick_cnt = s.tick_cnt + 1'b1;
      end

      // The request pin is asynchronous and is synchronised before use.
      next_s.req_s1 = BILLBOARD_REQ_N;
      next_s.req_s2 = s.req_s1;
      next_s.bb_enum = !s.req_s2;

      if (S_AXI_AWVALID && s.awready) begin
         next_s.awready = 1'b0;
         next_s.aw_got = 1'b1;
         next_s.aw_idx = S_AXI_AWADDR[spwd_pkg::AXI_AW-1:2];
      end
      if (S_AXI_WVALID && s.wready) begin
         next_s.wready = 1'b0;
         next_s.w_got = 1'b1;
         next_s.wdata = S_AXI_WDATA[7:0];
         next_s.wstrb0 = S_AXI_WSTRB[0];
      end
      if (have_aw && have_w && !s.bvalid) begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.awready = 1'b0;
         next_s.wready = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = spwd_pkg::RESP_OKAY;
         if (w_idx == spwd_pkg::IDX_SPLIT_EN) begin
            if (w_lane0) begin
               next_s.split_en = w_byte & spwd_pkg::MASK_SPLIT_EN;
            end
         end else if (w_idx == spwd_pkg::IDX_TIMEOUT) begin
            if (w_lane0) begin
               next_s.tsel = w_byte & spwd_pkg::MASK_TIMEOUT;
            end
         end else if (w_idx == spwd_pkg::IDX_PULSE) begin
            if (w_lane0) begin
               next_s.pulse = w_byte;
            end
         end else if (w_idx == spwd_pkg::IDX_STATUS) begin
            next_s.bresp = spwd_pkg::RESP_OKAY;
         end else begin
            next_s.bresp = spwd_pkg::RESP_SLVERR;
         end
      end
      if (s.bvalid && S_AXI_BREADY) begin
         next_s.bvalid = 1'b0;
         next_s.awready = 1'b1;
         next_s.wready = 1'b1;
      end

      if (S_AXI_ARVALID && s.arready) begin
         next_s.arready = 1'b0;
         next_s.rvalid = 1'b1;
         next_s.rresp = spwd_pkg::RESP_OKAY;
         next_s.rdata = '0;
         if (r_idx == spwd_pkg::IDX_SPLIT_EN) begin
            next_s.rdata[7:0] = s.split_en;
         end else if (r_idx == spwd_pkg::IDX_TIMEOUT) begin
            next_s.rdata[7:0] = s.tsel;
         end else if (r_idx == spwd_pkg::IDX_PULSE) begin
            next_s.rdata[7:0] = s.pulse;
         end else if (r_idx == spwd_pkg::IDX_STATUS) begin
            next_s.rdata[spwd_pkg::LS_W-1:0] = LINK_STATE_STATUS_P3;
            next_s.rdata[spwd_pkg::ST_P4_LSB +: spwd_pkg::LS_W] = LINK_STATE_STATUS_P4;
            next_s.rdata[spwd_pkg::ST_PULSE_P3] = pulsing_p3;
            next_s.rdata[spwd_pkg::ST_PULSE_P4] = pulsing_p4;
            next_s.rdata[spwd_pkg::ST_BILLBOARD] = s.bb_enum;
         end else begin
            next_s.rresp = spwd_pkg::RESP_SLVERR;
         end
      end
      if (s.rvalid && S_AXI_RREADY) begin
         next_s.rvalid = 1'b0;
         next_s.arready = 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         s <= '0;
         s.awready <= 1'b1;
         s.wready <= 1'b1;
         s.arready <= 1'b1;
         s.split_en <= spwd_pkg::RST_SPLIT_EN;
         s.tsel <= spwd_pkg::RST_TIMEOUT;
         s.pulse <= spwd_pkg::RST_PULSE;
         s.req_s1 <= 1'b1;
         s.req_s2 <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   spwd_port_timer u_timer_p3 (
      .clk        (CLK),
      .rst        (RST),
      .ms_tick    (s.ms_tick),
      .enable     (s.split_en[spwd_pkg::BIT_EN_P3]),
      .link_state (LINK_STATE_STATUS_P3),
      .timeout_ms (timeout_ms),
      .pulse_ms   (pulse_ms),
      .power      (SUPERSPEED_SPLIT_POWER_PIN_P3),
      .pulsing    (pulsing_p3)
   );

   spwd_port_timer u_timer_p4 (
      .clk        (CLK),
      .rst        (RST),
      .ms_tick    (s.ms_tick),
      .enable     (s.split_en[spwd_pkg::BIT_EN_P4]),
      .link_state (LINK_STATE_STATUS_P4),
      .timeout_ms (timeout_ms),
      .pulse_ms   (pulse_ms),
      .power      (SUPERSPEED_SPLIT_POWER_PIN_P4),
      .pulsing    (pulsing_p4)
   );

   // Failure text for the billboard descriptors.
   spwd_msg_mem #(
      .AW (MSG_AW),
      .DW (8)
   ) u_msg (
      .clk   (CLK),
      .we    (OTP_MSG_WE),
      .waddr (OTP_MSG_ADDR),
      .wdata (OTP_MSG_DATA),
      .raddr (DESC_ADDR),
      .rdata (DESC_DATA)
   );

   assign S_AXI_AWREADY = s.awready;
   assign S_AXI_WREADY = s.wready;
   assign S_AXI_BVALID = s.bvalid;
   assign S_AXI_BRESP = s.bresp;
   assign S_AXI_ARREADY = s.arready;
   assign S_AXI_RVALID = s.rvalid;
   assign S_AXI_RRESP = s.rresp;
   assign S_AXI_RDATA = s.rdata;
   assign BILLBOARD_ENUM = s.bb_enum;

   reset_values_a: assert property (@(posedge CLK) disable iff (RST)
      $past(RST) |-> (s.tsel == spwd_pkg::RST_TIMEOUT && s.split_en == spwd_pkg::RST_SPLIT_EN &&
                      s.pulse == spwd_pkg::RST_PULSE))
      else $error("Wrong register values after reset.");
   otp_override_a: assert property (@(posedge CLK) disable iff (RST)
      (OTP_TIMEOUT_VALID && OTP_TIMEOUT_SEL == 3'h1) |-> int'(timeout_ms) == spwd_pkg::TO_1_MS)
      else $error("OTP timeout select not applied.");
   billboard_follow_a: assert property (@(posedge CLK) disable iff (RST)
      (!BILLBOARD_REQ_N [*3]) |=> BILLBOARD_ENUM)
      else $error("Billboard not exposed after failure request.");
   billboard_release_a: assert property (@(posedge CLK) disable iff (RST)
      (BILLBOARD_REQ_N [*3]) |=> !BILLBOARD_ENUM)
      else $error("Billboard still exposed after request release.");
   split_gate_a: assert property (@(posedge CLK) disable iff (RST)
      !s.split_en[spwd_pkg::BIT_EN_P3] |=> SUPERSPEED_SPLIT_POWER_PIN_P3)
      else $error("Port 3 pulsed while split disabled.");
   split_gate_p4_a: assert property (@(posedge CLK) disable iff (RST)
      !s.split_en[spwd_pkg::BIT_EN_P4] |=> SUPERSPEED_SPLIT_POWER_PIN_P4)
      else $error("Port 4 pulsed while split disabled.");
   reserved_zero_a: assert property (@(posedge CLK) disable iff (RST)
      s.tsel[7:3] == '0 && !s.split_en[0])
      else $error("Reserved register bits set.");
   read_resp_a: assert property (@(posedge CLK) disable iff (RST)
      (S_AXI_ARVALID && s.arready) |=> (s.rvalid && !s.arready))
      else $error("Read answer missing after address.");
   write_resp_a: assert property (@(posedge CLK) disable iff (RST)
      (have_aw && have_w && !s.bvalid) |=> (s.bvalid && !s.awready && !s.wready))
      else $error("Write response missing after address and data.");
   write_hs_c: cover property (@(posedge CLK) disable iff (RST) s.bvalid && S_AXI_BREADY);
   billboard_c: cover property (@(posedge CLK) disable iff (RST) $rose(s.bb_enum));
   p4_pulse_c: cover property (@(posedge CLK) disable iff (RST) $fell(SUPERSPEED_SPLIT_POWER_PIN_P4));
endmodule
`default_nettype wire

/* File: verification/spwd_far_end.sv */
// Model of the embedded link partner and the external power delivery controller.
`default_nettype none
module spwd_far_end (
   input  wire logic       clk,
   input  wire logic       power_p3,
   input  wire logic       power_p4,
   input  wire logic [3:0] want_p3,
   input  wire logic [3:0] want_p4,
   input  wire logic       alt_fail,
   output var  logic [3:0] ls_p3,
   output var  logic [3:0] ls_p4,
   output var  logic       req_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // An unpowered device reports the off code, which lies outside the stuck list.
   always_ff @(posedge clk) begin
      ls_p3 <= power_p3 ? want_p3 : 4'h0;
      ls_p4 <= power_p4 ? want_p4 : 4'h0;
   end
   // A failed negotiation pulls the request line low.
   always_ff @(posedge clk) begin
      req_n <= !alt_fail;
   end
endmodule
`default_nettype wire

/* File: verification/tb_spwd_top.sv */
// Self-checking bench for the split port link watchdog.
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; \
   $display("mismatch at %0t: %h vs %h", $time, a, e); end end
module tb_spwd_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int          TK   = 4;
   localparam int          TO   = spwd_pkg::TO_1_MS * TK;
   localparam logic [17:0] A_EN = {spwd_pkg::IDX_SPLIT_EN, 2'b00};
   localparam logic [17:0] A_TO = {spwd_pkg::IDX_TIMEOUT, 2'b00};
   localparam logic [17:0] A_PU = {spwd_pkg::IDX_PULSE, 2'b00};
   localparam logic [17:0] A_ST = {spwd_pkg::IDX_STATUS, 2'b00};
   logic        clk, rst, awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr, otp_v, msg_we, alt_fail, p3, p4, req_n, bb;
   logic [17:0] awa, ara;
   logic [31:0] wd, rdd;
   logic [1:0]  bresp, rresp, be;
   logic [3:0]  want3, want4, ls3, ls4;
   logic [2:0]  otp_sel;
   logic [5:0]  maddr, daddr;
   logic [7:0]  mdata, ddata;
   logic [33:0] re;
   logic [1:0]  bq[$];
   logic [33:0] rq[$];
   int          pq[$];
   int          fails, cmp_count, npulse, lowc, c, n, pe;
   bit          armed, en4;

   spwd_top #(.TICK_CYCLES(TK), .MSG_AW(6)) u_dut (
      .CLK(clk), .RST(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
      .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
      .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdd),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .LINK_STATE_STATUS_P3(ls3),
      .LINK_STATE_STATUS_P4(ls4), .SUPERSPEED_SPLIT_POWER_PIN_P3(p3), .SUPERSPEED_SPLIT_POWER_PIN_P4(p4),
      .OTP_TIMEOUT_VALID(otp_v), .OTP_TIMEOUT_SEL(otp_sel), .OTP_MSG_WE(msg_we), .OTP_MSG_ADDR(maddr),
      .OTP_MSG_DATA(mdata), .BILLBOARD_REQ_N(req_n), .BILLBOARD_ENUM(bb), .DESC_ADDR(daddr), .DESC_DATA(ddata));

   spwd_far_end u_far (.clk(clk), .power_p3(p3), .power_p4(p4), .want_p3(want3), .want_p4(want4),
      .alt_fail(alt_fail), .ls_p3(ls3), .ls_p4(ls4), .req_n(req_n));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Compares every bus answer and every finished port 3 power pulse with the oldest note.
   always @(posedge clk) begin
      if (bv && br) begin
         be = bq.size() ? bq.pop_front() : 2'hx;
         `CHK(bresp, be)
      end
      if (rv && rr) begin
         re = rq.size() ? rq.pop_front() : 34'hx;
         `CHK({rresp, rdd}, re)
      end
      if (armed && p3 === 1'b0) lowc++;
      else if (armed && lowc != 0) begin
         pe = pq.size() ? pq.pop_front() : -1;
         `CHK(lowc, pe)
         npulse++;
         lowc = 0;
      end
      if (armed && !en4) `CHK(p4, 1'b1)
   end

   task automatic final_report();
      $display("comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic stall();
      fails++;
      final_report();
   endtask

   task automatic axw(input logic [17:0] a, input logic [7:0] d, input logic [1:0] resp);
      bq.push_back(resp);
      awa <= a;
      wd <= {24'h0, d};
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      for (c = 0; c < 50; c++) begin
         @(posedge clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wrdy) wv <= 1'b0;
         if (bv) break;
      end
      br <= 1'b0;
      @(posedge clk);
      if (c == 50) stall();
   endtask

   task automatic axr(input logic [17:0] a, input logic [33:0] e);
      rq.push_back(e);
      ara <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      for (c = 0; c < 50; c++) begin
         @(posedge clk);
         if (arv && arr) arv <= 1'b0;
         if (rv) break;
      end
      rr <= 1'b0;
      @(posedge clk);
      if (c == 50) stall();
   endtask

   // Holds the link in one state and times the dwell up to the pulse and the pulse itself.
   task automatic pulse(input logic [3:0] st, input logic [7:0] d);
      axw(A_PU, d, spwd_pkg::RESP_OKAY);
      pq.push_back((spwd_pkg::PULSE_MIN_MS + spwd_pkg::PULSE_STEP_MS * d) * TK);
      want3 <= st;
      for (c = 0; c < 3000 && p3 !== 1'b0; c++) @(posedge clk);
      `CHK(c inside {[TO - 16 : TO + 8]}, 1'b1)
      for (c = 0; c < 3000 && p3 !== 1'b1; c++) @(posedge clk);
      @(posedge clk);
      if (c == 3000) stall();
   endtask

   initial begin
      rst = 1'b1;
      {awv, wv, br, arv, rr, otp_v, msg_we, alt_fail, armed} = '0;
      {awa, ara, wd, otp_sel, maddr, daddr, mdata, want3} = '0;
      want4 = 4'h7;
      void'($urandom(17));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      armed <= 1'b1;
      @(posedge clk);
      axr(A_EN, 34'h0);
      axr(A_TO, 34'h5);
      axr(A_PU, 34'h5);
      axr(18'h10, {spwd_pkg::RESP_SLVERR, 32'h0});
      axw(18'h10, 8'h1, spwd_pkg::RESP_SLVERR);
      axw(A_EN, 8'h21, spwd_pkg::RESP_OKAY);
      axr(A_EN, 34'h20);
      axw(A_TO, 8'hf9, spwd_pkg::RESP_OKAY);
      axr(A_TO, 34'h1);
      for (n = 4; n <= 9; n++) pulse(4'(n), 8'($urandom % 4));
      pulse(4'h9, 8'h0);
      want3 <= 4'h0;
      axw(A_TO, 8'h0, spwd_pkg::RESP_OKAY);
      want3 <= 4'h7;
      repeat (3 * TO) @(posedge clk);
      want3 <= 4'h0;
      otp_sel <= 3'h1;
      otp_v <= 1'b1;
      repeat (4) @(posedge clk);
      pulse(4'h7, 8'h2);
      otp_v <= 1'b0;
      want3 <= 4'h0;
      axw(A_TO, 8'h1, spwd_pkg::RESP_OKAY);
      for (n = 0; n < 10; n++) begin
         want3 <= n[0] ? 4'h8 : 4'h7;
         repeat (TO / 2) @(posedge clk);
      end
      want3 <= 4'h0;
      en4 <= 1'b1;
      axw(A_EN, 8'h40, spwd_pkg::RESP_OKAY);
      for (c = 0; c < 3000 && p4 !== 1'b0; c++) @(posedge clk);
      `CHK(c inside {[TO - 16 : TO + 8]}, 1'b1)
      axr(A_ST, 34'h200);
      axw(A_EN, 8'h0, spwd_pkg::RESP_OKAY);
      `CHK(p4, 1'b1)
      en4 <= 1'b0;
      axr(A_ST, 34'h70);
      alt_fail <= 1'b1;
      for (c = 0; c < 10 && bb !== 1'b1; c++) @(posedge clk);
      `CHK(c <= 5, 1'b1)
      alt_fail <= 1'b0;
      for (c = 0; c < 10 && bb !== 1'b0; c++) @(posedge clk);
      `CHK(bb, 1'b0)
      mdata <= 8'($urandom);
      maddr <= 6'h5;
      msg_we <= 1'b1;
      daddr <= 6'h5;
      @(posedge clk);
      msg_we <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK(ddata, mdata)
      `CHK(pq.size(), 0)
      final_report();
   end
endmodule
`default_nettype wire
